// *** sap_serial_audio.sv ***
/*
  Serial audio block: serial and PDM receive, serial/PDM/parallel transmit,
  master or slave bit clock, register port with one-cycle read latency.
  Assumes link pins arrive asynchronously and are synchronised here, and
  an external pad resolves the BCK, WS and SD enables into wire levels.
*/
// Local design decisions: the register offsets and the plain strobed port.
`default_nettype none

module sap_serial_audio
  import sap_pkg::*;
(
  input  wire logic        SYS_CLK,
  input  wire logic        RESET,
  input  wire logic [5:0]  ADDR,
  input  wire logic [31:0] WDATA,
  input  wire logic        WRITE_STROBE,
  input  wire logic        READ_STROBE,
  output var  logic [31:0] RDATA,
  input  wire logic        BCK_IN,
  output var  logic        BCK_OUT,
  output var  logic        BCK_OE,
  input  wire logic        WORD_SELECT_INPUT,
  output var  logic        WORD_SELECT_OUTPUT,
  output var  logic        WS_OE,
  input  wire logic        SD_IN,
  output var  logic        SD_OUT,
  output var  logic        SD_OE,
  output var  logic [23:0] LCD_DATA
);

  typedef struct packed {
    logic [2:0]  sync1;
    logic [2:0]  sync2;
    logic [1:0]  sync3;
    logic [9:0]  conf;
    logic [2:0]  fmt;
    logic [2:0]  chan;
    logic [7:0]  div;
    logic [5:0]  pdm_ctl;
    logic [3:0]  osr2;
    logic [9:0]  fp;
    logic [9:0]  fs;
    logic [2:0]  lcd_ctl;
    logic [7:0]  div_cnt;
    logic        bck;
    logic        bck_oe;
    logic        ws;
    logic        ws_oe;
    logic        sd;
    logic        sd_oe;
    logic [3:0]  bit_cnt;
    logic [31:0] tx_word;
    logic        tx_full;
    logic [15:0] tx_shift;
    logic        tx_ws_seen;
    logic [15:0] rx_shift;
    logic [4:0]  rx_cnt;
    logic        rx_ws_seen;
    logic        rx_was_run;
    logic        skip_first;
    logic        have_first;
    logic        first_ch;
    logic [15:0] first_smp;
    logic [31:0] out0;
    logic [31:0] out1;
    logic [1:0]  out_cnt;
    logic        overflow;
    logic [7:0]  pdm_cnt;
    logic [7:0]  ones;
    logic [5:0]  stage2_cnt;
    logic [3:0]  inter_cnt;
    logic        extra;
    logic [10:0] frac_acc;
    logic [15:0] hp_dc;
    logic [15:0] cur_pcm;
    logic [17:0] sd_acc;
    logic [1:0]  lcd_phase;
    logic [23:0] lcd_data;
    logic [31:0] rdata;
  } sap_state_type;

  sap_state_type  q;
  sap_state_type  n;
  sap_txmode_type txmode;

  logic        s_bck, s_ws, s_sd, s_rise, s_fall;
  logic        tx_run, rx_run, tx_master, rx_master, master_on;
  logic        pdm_tx, pdm_rx, toggle, m_rise, m_fall;
  logic        tx_edge, tx_ws, tx_load, consume;
  logic        rx_edge, rx_ws, smp_done, pair_valid, pop;
  logic [15:0] tx_half, smp, lw, rw, a_smp, b_smp, sel_smp, x_pcm, hp;
  logic [15:0] rx_shift_n;
  logic [4:0]  rx_cnt_n;
  logic [17:0] sd_sum, dec18;
  logic [13:0] prod;
  logic [9:0]  rem;
  logic [11:0] sum_f;
  logic [8:0]  diff9;
  logic [7:0]  ones_n, dec_last, dec_mid;
  logic [1:0]  push_n, cnt_c, lcd_lim;
  logic [31:0] w0, w1, o0, o1;

  // ------------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------------
  always_comb begin
    n = q;
    // Pin synchronisers: first stage feeds only the second
    n.sync1 = {SD_IN, WORD_SELECT_INPUT, BCK_IN};
    n.sync2 = q.sync1;
    n.sync3 = q.sync2[1:0];
    s_bck  = q.sync2[0];
    s_ws   = q.sync2[1];
    s_sd   = q.sync2[2];
    s_rise = s_bck & ~q.sync3[0];
    s_fall = ~s_bck & q.sync3[0];

    tx_run    = q.conf[B_TX_RUN] & ~q.conf[B_TX_RESET];
    rx_run    = q.conf[B_RX_RUN] & ~q.conf[B_RX_RESET];
    tx_master = tx_run & ~q.conf[B_TX_SLAVE];
    rx_master = rx_run & ~q.conf[B_RX_SLAVE];
    master_on = tx_master | rx_master;
    pdm_tx    = q.pdm_ctl[B_TX_PDM_ON] & q.pdm_ctl[B_PCM2PDM_ON];
    pdm_rx    = q.pdm_ctl[B_RX_PDM_ON] & q.pdm_ctl[B_PDM2PCM_ON];

    if (!tx_run) begin
      txmode = TXM_IDLE;
    end else if (tx_master && q.lcd_ctl[B_PAR_ON]) begin
      txmode = TXM_LCD;
    end else if (tx_master && pdm_tx) begin
      txmode = TXM_PDM;
    end else begin
      txmode = TXM_SERIAL;
    end

    // Bit clock divider, runs while either direction is master
    toggle = 1'b0;
    if (master_on) begin
      if (q.div_cnt == q.div) begin
        n.div_cnt = 8'h00;
        toggle    = 1'b1;
      end else begin
        n.div_cnt = q.div_cnt + 8'h01;
      end
    end else begin
      n.div_cnt = 8'h00;
    end
    m_rise   = toggle & ~q.bck;
    m_fall   = toggle & q.bck;
    n.bck    = master_on ? (q.bck ^ toggle) : 1'b0;
    n.bck_oe = master_on;
    n.ws_oe  = master_on;

    // Word select: PDM clock, display strobe or channel select
    if (!master_on) begin
      n.ws      = 1'b0;
      n.bit_cnt = 4'h0;
    end else if ((txmode == TXM_PDM) || (rx_master && pdm_rx)) begin
      n.ws = q.bck ^ toggle;
    end else if (txmode == TXM_LCD) begin
      if (m_rise) begin
        n.ws = ~q.ws;
      end
    end else if (m_fall) begin
      n.bit_cnt = q.bit_cnt + 4'h1;
      if (q.bit_cnt == BIT_LAST) begin
        n.ws = ~q.ws;
      end
    end

    // ----------------------------------------------------------------
    // Transmit side
    // ----------------------------------------------------------------
    consume  = 1'b0;
    tx_edge  = tx_master ? m_fall : s_fall;
    tx_ws    = tx_master ? n.ws : s_ws;
    tx_load  = tx_master ? (q.bit_cnt == BIT_LAST) : (s_ws != q.tx_ws_seen);
    tx_half  = tx_ws ? q.tx_word[15:0] : q.tx_word[31:16];
    prod     = {10'h000, q.osr2} * {4'h0, q.fs};
    rem      = ({4'h0, q.fp} > prod) ? 10'({4'h0, q.fp} - prod) : 10'h000;
    sum_f    = {1'b0, q.frac_acc} + {2'h0, rem};
    x_pcm    = q.tx_word[31:16];
    hp       = x_pcm - q.hp_dc;
    sd_sum   = q.sd_acc + {{2{q.cur_pcm[15]}}, q.cur_pcm};
    lcd_lim  = {q.lcd_ctl[B_DATA_DOUBLE] & q.lcd_ctl[B_WR_DOUBLE],
                q.lcd_ctl[B_DATA_DOUBLE] | q.lcd_ctl[B_WR_DOUBLE]};
    n.sd_oe  = (txmode != TXM_IDLE) && (txmode != TXM_LCD);

    case (txmode)
      TXM_SERIAL: begin
        if (tx_edge) begin
          if (tx_load) begin
            n.sd         = tx_half[15];
            n.tx_shift   = {tx_half[14:0], 1'b0};
            n.tx_ws_seen = tx_ws;
            consume      = tx_ws;
          end else begin
            n.sd       = q.tx_shift[15];
            n.tx_shift = {q.tx_shift[14:0], 1'b0};
          end
        end
      end
      TXM_PDM: begin
        if (m_rise) begin
          // Second stage: sigma-delta at the PDM rate
          n.sd         = ~sd_sum[17];
          n.sd_acc     = sd_sum - (sd_sum[17] ? SD_NEG : SD_POS);
          n.stage2_cnt = q.stage2_cnt + 6'h01;
          if (q.stage2_cnt == STAGE2_LAST) begin
            // First stage: osr2 steps plus fractional fp/fs carry
            if (({1'b0, q.inter_cnt} + 5'h01) >=
                ({1'b0, q.osr2} + {4'h0, q.extra})) begin
              n.inter_cnt = 4'h0;
              consume     = 1'b1;
              n.hp_dc     = q.hp_dc + {{6{hp[15]}}, hp[15:6]};
              n.cur_pcm   = q.pdm_ctl[B_HP_BYPASS] ? x_pcm : hp;
              if (sum_f >= {2'h0, q.fs}) begin
                n.extra    = 1'b1;
                n.frac_acc = 11'(sum_f - {2'h0, q.fs});
              end else begin
                n.extra    = 1'b0;
                n.frac_acc = sum_f[10:0];
              end
            end else begin
              n.inter_cnt = q.inter_cnt + 4'h1;
            end
          end
        end
      end
      TXM_LCD: begin
        if (m_rise && q.ws) begin
          if (q.lcd_phase == lcd_lim) begin
            n.lcd_phase = 2'h0;
            n.lcd_data  = q.tx_word[23:0];
            consume     = 1'b1;
          end else begin
            n.lcd_phase = q.lcd_phase + 2'h1;
          end
        end
      end
      TXM_IDLE: begin
        n.sd         = 1'b0;
        n.tx_shift   = 16'h0000;
        n.stage2_cnt = 6'h00;
        n.inter_cnt  = 4'h0;
        n.lcd_phase  = 2'h0;
        n.tx_ws_seen = 1'b0;
      end
      default: begin
        n.sd = 1'b0;
      end
    endcase
    if (consume) begin
      n.tx_full = 1'b0;
    end

    // ----------------------------------------------------------------
    // Receive side
    // ----------------------------------------------------------------
    rx_edge    = rx_run & (rx_master ? m_rise : s_rise);
    rx_ws      = rx_master ? q.ws : s_ws;
    rx_shift_n = {q.rx_shift[14:0], s_sd};
    rx_cnt_n   = (rx_ws != q.rx_ws_seen) ? 5'h01 :
                 ((q.rx_cnt == SAMPLE_FULL) ? SAMPLE_FULL : q.rx_cnt + 5'h01);
    smp_done   = 1'b0;
    smp        = rx_shift_n;
    pair_valid = 1'b0;
    lw         = q.first_ch ? rx_shift_n : q.first_smp;
    rw         = q.first_ch ? q.first_smp : rx_shift_n;
    dec_last   = q.pdm_ctl[B_DSR16] ? DEC128_LAST : DEC64_LAST;
    dec_mid    = q.pdm_ctl[B_DSR16] ? DEC128_MID : DEC64_MID;
    ones_n     = q.ones + {7'h00, s_sd};
    diff9      = {1'b0, ones_n} - {1'b0, dec_mid};
    dec18      = 18'({{9{diff9[8]}}, diff9} << (q.pdm_ctl[B_DSR16] ? 9 : 10));
    n.rx_was_run = rx_run;

    if (rx_run && !q.rx_was_run) begin
      n.skip_first = q.conf[B_RIGHT_FIRST];
      n.have_first = 1'b0;
      n.rx_cnt     = 5'h00;
      n.pdm_cnt    = 8'h00;
      n.ones       = 8'h00;
    end else if (rx_master && pdm_rx) begin
      if (m_rise) begin
        if (q.pdm_cnt == dec_last) begin
          n.pdm_cnt  = 8'h00;
          n.ones     = 8'h00;
          pair_valid = 1'b1;
          lw = (!dec18[17] && (dec18[16:15] != 2'h0)) ? PCM_MAX : dec18[15:0];
          rw = lw;
        end else begin
          n.pdm_cnt = q.pdm_cnt + 8'h01;
          n.ones    = ones_n;
        end
      end
    end else if (rx_edge) begin
      n.rx_shift   = rx_shift_n;
      n.rx_ws_seen = rx_ws;
      n.rx_cnt     = rx_cnt_n;
      smp_done     = (rx_cnt_n == SAMPLE_FULL) && (q.rx_cnt != SAMPLE_FULL);
    end

    if (smp_done) begin
      if (q.skip_first) begin
        n.skip_first = 1'b0;
      end else if (!q.have_first) begin
        n.have_first = 1'b1;
        n.first_smp  = smp;
        n.first_ch   = rx_ws;
      end else begin
        n.have_first = 1'b0;
        pair_valid   = 1'b1;
      end
    end

    // Pair layout into queue words
    a_smp   = q.conf[B_MSB_RIGHT] ? rw : lw;
    b_smp   = q.conf[B_MSB_RIGHT] ? lw : rw;
    sel_smp = (q.chan == CHAN_RIGHT) ? rw : lw;
    w0      = {a_smp, 16'h0000};
    w1      = {b_smp, 16'h0000};
    push_n  = 2'h0;
    if (pair_valid) begin
      case (q.fmt)
        FMT_16_DUAL: begin
          w0     = {a_smp, b_smp};
          push_n = 2'h1;
        end
        FMT_16_SINGLE: begin
          w0     = {sel_smp, sel_smp};
          push_n = 2'h1;
        end
        FMT_32_DUAL: begin
          push_n = 2'h2;
        end
        FMT_32_SINGLE: begin
          w0     = {sel_smp, 16'h0000};
          push_n = 2'h1;
        end
        default: begin
          push_n = 2'h0;
        end
      endcase
    end

    // Two-word receive queue; a pop and a push may share a cycle
    pop   = READ_STROBE && (ADDR == A_RXD) && (q.out_cnt != 2'h0);
    cnt_c = q.out_cnt;
    o0    = q.out0;
    o1    = q.out1;
    if (pop) begin
      o0    = q.out1;
      cnt_c = q.out_cnt - 2'h1;
    end
    if (push_n != 2'h0) begin
      if ((3'(cnt_c) + 3'(push_n)) > 3'h2) begin
        n.overflow = 1'b1;
      end else if (cnt_c == 2'h0) begin
        o0    = w0;
        o1    = w1;
        cnt_c = push_n;
      end else begin
        o1    = w0;
        cnt_c = cnt_c + push_n;
      end
    end
    n.out0    = o0;
    n.out1    = o1;
    n.out_cnt = cnt_c;

    // ----------------------------------------------------------------
    // Register port
    // ----------------------------------------------------------------
    if (WRITE_STROBE) begin
      case (ADDR)
        A_CONF: n.conf = WDATA[9:0];
        A_FMT: begin
          n.fmt  = WDATA[2:0];
          n.chan = WDATA[F_CHAN_LO +: 3];
        end
        A_CLK: n.div = WDATA[7:0];
        A_PDM: begin
          n.pdm_ctl = WDATA[5:0];
          n.osr2    = WDATA[F_OSR2_LO +: 4];
        end
        A_PDMF: begin
          n.fp = WDATA[9:0];
          n.fs = WDATA[F_FS_LO +: 10];
        end
        A_LCD: n.lcd_ctl = WDATA[2:0];
        A_TXD: begin
          n.tx_word = WDATA;
          n.tx_full = 1'b1;
        end
        A_STAT: begin
          if (WDATA[B_ST_OVF] && !(n.overflow && !q.overflow)) begin
            n.overflow = 1'b0;
          end
        end
        default: begin
          n.conf = q.conf;
        end
      endcase
    end

    // Unit and queue resets held while their bit is set
    if (q.conf[B_TXF_RESET]) begin
      n.tx_full = 1'b0;
    end
    if (q.conf[B_RXF_RESET]) begin
      n.out_cnt  = 2'h0;
      n.overflow = 1'b0;
    end
    if (q.conf[B_RX_RESET]) begin
      n.have_first = 1'b0;
      n.rx_cnt     = 5'h00;
      n.rx_shift   = 16'h0000;
    end

    n.rdata = 32'h0000_0000;
    if (READ_STROBE) begin
      case (ADDR)
        A_CONF: n.rdata = {22'h0, q.conf};
        A_FMT:  n.rdata = {25'h0, q.chan, 1'b0, q.fmt};
        A_CLK:  n.rdata = {24'h0, q.div};
        A_PDM:  n.rdata = {20'h0, q.osr2, 2'h0, q.pdm_ctl};
        A_PDMF: n.rdata = {6'h0, q.fs, 6'h0, q.fp};
        A_LCD:  n.rdata = {29'h0, q.lcd_ctl};
        A_TXD:  n.rdata = q.tx_word;
        A_RXD:  n.rdata = (q.out_cnt != 2'h0) ? q.out0 : 32'h0000_0000;
        A_STAT: n.rdata = {27'h0, q.have_first, q.overflow, q.out_cnt, q.tx_full};
        default: n.rdata = 32'h0000_0000;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // State register
  // ------------------------------------------------------------------
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      q      <= '0;
      q.div  <= DIV_RST;
      q.fp   <= FP_RST;
      q.fs   <= FS_RST;
      q.osr2 <= OSR2_RST;
    end else begin
      q <= n;
    end
  end

  assign RDATA              = q.rdata;
  assign BCK_OUT            = q.bck;
  assign BCK_OE             = q.bck_oe;
  assign WORD_SELECT_OUTPUT = q.ws;
  assign WS_OE              = q.ws_oe;
  assign SD_OUT             = q.sd;
  assign SD_OE              = q.sd_oe;
  assign LCD_DATA           = q.lcd_data;

endmodule

`default_nettype wire

// *** sap_pkg.sv ***
/*
  Package for the serial audio receive, PDM and parallel display block.
  Holds register offsets, bit positions, reset values and fixed counts.
  Assumes a single 25 MHz system clock and a simple strobed register port.
*/
`default_nettype none

package sap_pkg;

  // ------------------------------------------------------------------
  // Register offsets (byte addresses)
  // ------------------------------------------------------------------
  localparam logic [5:0] A_CONF  = 6'h00;
  localparam logic [5:0] A_FMT   = 6'h04;
  localparam logic [5:0] A_CLK   = 6'h08;
  localparam logic [5:0] A_PDM   = 6'h0C;
  localparam logic [5:0] A_PDMF  = 6'h10;
  localparam logic [5:0] A_LCD   = 6'h14;
  localparam logic [5:0] A_TXD   = 6'h18;
  localparam logic [5:0] A_RXD   = 6'h1C;
  localparam logic [5:0] A_STAT  = 6'h20;

  // ------------------------------------------------------------------
  // Bit positions
  // ------------------------------------------------------------------
  localparam int B_TX_RUN      = 0;
  localparam int B_RX_RUN      = 1;
  localparam int B_TX_SLAVE    = 2;
  localparam int B_RX_SLAVE    = 3;
  localparam int B_RIGHT_FIRST = 4;
  localparam int B_MSB_RIGHT   = 5;
  localparam int B_TX_RESET    = 6;
  localparam int B_RX_RESET    = 7;
  localparam int B_TXF_RESET   = 8;
  localparam int B_RXF_RESET   = 9;

  localparam int B_TX_PDM_ON   = 0;
  localparam int B_PCM2PDM_ON  = 1;
  localparam int B_RX_PDM_ON   = 2;
  localparam int B_PDM2PCM_ON  = 3;
  localparam int B_HP_BYPASS   = 4;
  localparam int B_DSR16       = 5;
  localparam int F_OSR2_LO     = 8;
  localparam int F_CHAN_LO     = 4;
  localparam int F_FS_LO       = 16;

  localparam int B_PAR_ON      = 0;
  localparam int B_WR_DOUBLE   = 1;
  localparam int B_DATA_DOUBLE = 2;

  localparam int B_ST_TXFULL   = 0;
  localparam int F_ST_CNT_LO   = 1;
  localparam int B_ST_OVF      = 3;
  localparam int B_ST_HALF     = 4;

  // ------------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------------
  localparam logic [7:0] DIV_RST  = 8'h03;
  localparam logic [9:0] FP_RST   = 10'h3C0;
  localparam logic [9:0] FS_RST   = 10'h1E0;
  localparam logic [3:0] OSR2_RST = 4'h2;

  // ------------------------------------------------------------------
  // Format codes and fixed counts
  // ------------------------------------------------------------------
  localparam logic [2:0] FMT_16_DUAL   = 3'h0;
  localparam logic [2:0] FMT_16_SINGLE = 3'h1;
  localparam logic [2:0] FMT_32_DUAL   = 3'h2;
  localparam logic [2:0] FMT_32_SINGLE = 3'h3;
  localparam logic [2:0] CHAN_RIGHT    = 3'h2;

  localparam logic [3:0]  BIT_LAST    = 4'hF;
  localparam logic [4:0]  SAMPLE_FULL = 5'h10;
  localparam logic [5:0]  STAGE2_LAST = 6'h3F;
  localparam logic [7:0]  DEC128_LAST = 8'h7F;
  localparam logic [7:0]  DEC64_LAST  = 8'h3F;
  localparam logic [7:0]  DEC128_MID  = 8'h40;
  localparam logic [7:0]  DEC64_MID   = 8'h20;
  localparam logic [17:0] SD_POS      = 18'h07FFF;
  localparam logic [17:0] SD_NEG      = 18'h38000;
  localparam logic [15:0] PCM_MAX     = 16'h7FFF;

  typedef enum logic [1:0] {TXM_IDLE, TXM_SERIAL, TXM_PDM, TXM_LCD} sap_txmode_type;

endpackage

`default_nettype wire

// *** sap_codec_model.sv ***
/* Far-side codec model: sends one fixed frame on the master bit clock.
   Assumes clock and enable come straight from the block's pins. */
`default_nettype none
module sap_codec_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        bck,
  input  wire logic        bck_oe,
  input  wire logic [31:0] frame,
  output var  logic        sd
);
  logic [4:0] idx_q;
  logic       bck_q;
  logic [4:0] nxt;
  assign nxt = idx_q + {4'h0, bck_q && !bck};
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      idx_q <= 5'h00;
      bck_q <= 1'b0;
      sd    <= 1'b0;
    end else begin
      bck_q <= bck;
      idx_q <= bck_oe ? nxt : 5'h00;
      // Left then right, MSB first; wanders while released
      sd    <= bck_oe ? frame[~nxt] : ~sd;
    end
  end
endmodule
`default_nettype wire

// *** sap_serial_audio_properties.sv ***
/* Port checker for the serial audio block.
   Assumes binding onto sap_serial_audio; config tracked from writes. */
`default_nettype none
module sap_serial_audio_properties
  import sap_pkg::*;
(
  input wire logic        SYS_CLK,
  input wire logic        RESET,
  input wire logic [5:0]  ADDR,
  input wire logic [31:0] WDATA,
  input wire logic        WRITE_STROBE,
  input wire logic        READ_STROBE,
  input wire logic [31:0] RDATA,
  input wire logic        BCK_OUT,
  input wire logic        BCK_OE,
  input wire logic        WS_OE,
  input wire logic        SD_OUT,
  input wire logic        SD_OE
);
  logic [3:0] conf_q;
  logic [7:0] div_q;
  logic [7:0] cnt_q;
  logic       bck_q;
  logic       seen_q;
  logic       chg;
  logic       txm;
  logic       rxm;
  logic       pdm_q;
  assign chg = BCK_OUT != bck_q;
  assign txm = conf_q[0] && !conf_q[2];
  assign rxm = conf_q[1] && !conf_q[3];
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      conf_q <= 4'h0;
      div_q  <= DIV_RST;
      cnt_q  <= 8'h00;
      bck_q  <= 1'b0;
      seen_q <= 1'b0;
      pdm_q  <= 1'b0;
    end else begin
      if (WRITE_STROBE && ADDR == A_PDM) pdm_q <= WDATA[0] && WDATA[1];
      if (WRITE_STROBE && ADDR == A_CONF) conf_q <= WDATA[3:0];
      if (WRITE_STROBE && ADDR == A_CLK) div_q <= WDATA[7:0];
      cnt_q  <= chg ? 8'h00 : cnt_q + 8'h01;
      bck_q  <= BCK_OUT;
      seen_q <= BCK_OE && (seen_q || chg);
    end
  end
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (RESET);
  a_rdata_idle: assert property (!$past(READ_STROBE) |-> RDATA == 32'h0)
    else $error("read data outside read slot");
  a_unmapped_read: assert property ($past(READ_STROBE) && $past(ADDR) > A_STAT |-> RDATA == 32'h0)
    else $error("unmapped read not zero");
  a_idle_quiet: assert property ((conf_q[1:0] == 2'h0) [*3] |-> !BCK_OE && !WS_OE && !SD_OE)
    else $error("pins driven while stopped");
  a_slave_no_clock: assert property ((conf_q[3:2] == 2'h3) [*3] |-> !BCK_OE)
    else $error("slave drives bit clock");
  a_master_ws: assert property ((txm || rxm) [*3] |-> WS_OE)
    else $error("master not driving word select");
  a_rx_master_bck: assert property (rxm [*3] |-> BCK_OE)
    else $error("receive master not clocking");
  a_sd_on_low: assert property ($changed(SD_OUT) && $past(SD_OE) && SD_OE && div_q != 8'h00
    && txm && !pdm_q |-> !BCK_OUT)
    else $error("data changed with clock high");
  a_bck_half_period: assert property (chg && BCK_OE && seen_q |-> cnt_q == div_q)
    else $error("bit clock half period wrong");
endmodule
bind sap_serial_audio sap_serial_audio_properties u_props (
  .SYS_CLK, .RESET, .ADDR, .WDATA, .WRITE_STROBE, .READ_STROBE,
  .RDATA, .BCK_OUT, .BCK_OE, .WS_OE, .SD_OUT, .SD_OE
);
`default_nettype wire

// *** sap_serial_audio_tb_top.sv ***
/* Self-checking bench: register port, serial receive formats, transmit.
   Assumes the codec model on the data input and 25 MHz clock. */
`default_nettype none
module sap_serial_audio_tb_top;
  import sap_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk   = 1'b0;
  logic        rst   = 1'b1;
  logic [5:0]  addr  = 6'h00;
  logic [31:0] wdata = 32'h0;
  logic        wr    = 1'b0;
  logic        rd    = 1'b0;
  logic        rd_q  = 1'b0;
  logic [31:0] frame = 32'h0;
  logic [31:0] rdata;
  logic        bck_out, bck_oe, ws_out, ws_oe, sd_in, sd_out, sd_oe;
  logic [23:0] lcd;
  int          mismatches = 0;
  int          n_compared = 0;
  logic [31:0] exp_q[$];
  logic [5:0]  ra[7] = '{A_CONF, A_FMT, A_CLK, A_PDM, A_PDMF, A_STAT, 6'h24};
  logic [31:0] rv[7] = '{32'h0, 32'h0, 32'h3, 32'h200, 32'h01E003C0, 32'h0, 32'h0};
  logic [31:0] sf[5] = '{32'h0, 32'h21, 32'h2, 32'h13, 32'h0};
  logic [31:0] sc[5] = '{32'h0, 32'h0, 32'h20, 32'h0, 32'h30};

  sap_serial_audio DUT (.SYS_CLK(clk), .RESET(rst), .ADDR(addr), .WDATA(wdata),
    .WRITE_STROBE(wr), .READ_STROBE(rd), .RDATA(rdata), .BCK_IN(1'b0),
    .BCK_OUT(bck_out), .BCK_OE(bck_oe), .WORD_SELECT_INPUT(1'b0),
    .WORD_SELECT_OUTPUT(ws_out), .WS_OE(ws_oe), .SD_IN(sd_in), .SD_OUT(sd_out),
    .SD_OE(sd_oe), .LCD_DATA(lcd));
  sap_codec_model u_codec (.clk(clk), .rst(rst), .bck(bck_out), .bck_oe(bck_oe),
    .frame(frame), .sd(sd_in));

  initial begin
    forever #20 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    n_compared++;
    if (seen !== want) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, seen, want);
    end
  endtask

  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic wreg(input logic [5:0] a, input logic [31:0] v);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rreg(input logic [5:0] a, input logic [31:0] v);
    addr <= a;
    rd   <= 1'b1;
    exp_q.push_back(v);
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
  endtask

  // Read data stand in the cycle after the strobe
  always @(posedge clk) begin
    rd_q <= rd;
    if (rd_q) check(rdata, exp_q.pop_front());
  end

  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    test_done();
  end

  initial begin
    logic [15:0] l;
    logic [15:0] r;
    logic [31:0] d;
    logic [31:0] e;
    void'($urandom(32'h77CD));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    wreg(6'h24, 32'hFFFFFFFF);
    for (int i = 0; i < 7; i++) rreg(ra[i], rv[i]);
    d = $urandom();
    wreg(A_FMT, d);
    rreg(A_FMT, d & 32'h77);
    wreg(A_CLK, 32'h7);
    for (int i = 0; i < 5; i++) begin
      l = 16'($urandom());
      r = 16'($urandom());
      frame <= {l, r};
      wreg(A_FMT, sf[i]);
      wreg(A_CONF, sc[i] | 32'h280);
      wreg(A_CONF, sc[i] | 32'h2);
      repeat (900) @(posedge clk);
      case (i)
        0: e = {l, r};
        1: e = {r, r};
        2: e = {r, 16'h0};
        3: e = {l, 16'h0};
        default: e = {r, l};
      endcase
      rreg(A_RXD, e);
      if (i == 2) rreg(A_RXD, {l, 16'h0});
      wreg(A_CONF, 32'h0);
    end
    wreg(A_CONF, 32'h280);
    wreg(A_CONF, 32'hE);
    repeat (600) @(posedge clk);
    rreg(A_STAT, 32'h0);
    wreg(A_CONF, 32'h0);
    wreg(A_TXD, d);
    rreg(A_STAT, 32'h1);
    rreg(A_TXD, d);
    wreg(A_CONF, 32'h1);
    repeat (1200) @(posedge clk);
    @(negedge clk);
    check({29'h0, bck_oe, ws_oe, sd_oe}, 32'h7);
    @(posedge clk);
    rreg(A_STAT, 32'h0);
    wreg(A_CONF, 32'h0);
    repeat (3) @(posedge clk);
    @(negedge clk);
    check({29'h0, bck_oe, ws_oe, sd_oe}, 32'h0);
    @(posedge clk);
    wreg(A_PDMF, 32'h01E003C0);
    wreg(A_PDM, 32'h203);
    wreg(A_TXD, d);
    wreg(A_CONF, 32'h1);
    repeat (2300) @(posedge clk);
    @(negedge clk);
    check({30'h0, ws_out, sd_oe}, {30'h0, bck_out, 1'b1});
    @(posedge clk);
    rreg(A_STAT, 32'h0);
    wreg(A_CONF, 32'h0);
    wreg(A_PDM, 32'h0);
    wreg(A_LCD, 32'h1);
    wreg(A_TXD, ~d);
    wreg(A_CONF, 32'h1);
    repeat (200) @(posedge clk);
    @(negedge clk);
    check({8'h0, lcd}, {8'h0, ~d[23:0]});
    @(posedge clk);
    rreg(A_STAT, 32'h0);
    wreg(A_CONF, 32'h0);
    test_done();
  end
endmodule
`default_nettype wire
